// *** rtl/mbb_pkg.sv ***
// Package: register map, field layout and constants of the memory bank boundary registers
// Notes on behaviour
// - Lower bound is 00, extended start, start, then twenty zero bits.
// - Upper bound is 00, extended end, end, then twenty one bits.
// - Start register at 0x80 holds start fields of banks 0-3, one per byte.
// - Start register at 0x84 holds start fields of banks 4-7, one per byte.
// - Extended start at 0x88: 2-bit fields banks 0-3, upper six bits reserved.
// - Extended start at 0x8C: same layout for banks 4-7.
// - End register at 0x90 holds end fields of banks 0-3, one per byte.
// - End banks 4-7 at 0x94; extended end at 0x98 and 0x9C.
// - Enable register at 0xA0 bit n enables bank n; disabled never hits.
package mbb_pkg;
  // ********************************************************
  // Register offsets
  // ********************************************************
  localparam logic [7:0] MBB_OFF_START_LO   = 8'h80;
  localparam logic [7:0] MBB_OFF_START_HI   = 8'h84;
  localparam logic [7:0] MBB_OFF_SEXT_LO    = 8'h88;
  localparam logic [7:0] MBB_OFF_SEXT_HI    = 8'h8C;
  localparam logic [7:0] MBB_OFF_END_LO     = 8'h90;
  localparam logic [7:0] MBB_OFF_END_HI     = 8'h94;
  localparam logic [7:0] MBB_OFF_EEXT_LO    = 8'h98;
  localparam logic [7:0] MBB_OFF_EEXT_HI    = 8'h9C;
  localparam logic [7:0] MBB_OFF_BANK_EN    = 8'hA0;
  localparam logic [7:0] MBB_OFF_MEM_CTRL   = 8'hF0;
  localparam logic [7:0] MBB_OFF_HIT_STATUS = 8'hA4;
  // ********************************************************
  // Field layout and sizes
  // ********************************************************
  localparam int MBB_BANKS      = 8;
  localparam int MBB_HALF       = 4;
  localparam int MBB_LANE_W     = 8;
  localparam int MBB_EXT_W      = 2;
  localparam int MBB_LOW_W      = 20;
  localparam int MBB_MEMORY_GO_BIT_BIT  = 19;
  localparam logic [1:0]  MBB_TOP_ZERO  = 2'h0;
  localparam logic [19:0] MBB_LOW_ZERO  = 20'h0_0000;
  localparam logic [19:0] MBB_LOW_ONES  = 20'hF_FFFF;
  localparam logic [31:0] MBB_RST_WORD  = 32'h0000_0000;
  localparam logic [31:0] MBB_EXT_MASK  = 32'h0303_0303;
  localparam logic [31:0] MBB_EN_MASK   = 32'h0000_00FF;
  localparam logic [31:0] MBB_GO_MASK   = 32'h0008_0000;
endpackage

// *** rtl/mbb_bank_if.sv ***
// Interface: per-bank boundary fields and enables passed to the decoder
`timescale 1ns/10ps
`default_nettype none
interface mbb_bank_if;
  logic [7:0] start_f [8];
  logic [1:0] sext_f  [8];
  logic [7:0] end_f   [8];
  logic [1:0] eext_f  [8];
  logic [7:0] enable;
  modport regs (output start_f, sext_f, end_f, eext_f, enable);
  modport dec  (input start_f, sext_f, end_f, eext_f, enable);
endinterface
`default_nettype wire

// *** rtl/mbb_decode.sv ***
// Module: per-bank boundary arithmetic and address hit decode
`timescale 1ns/10ps
`default_nettype none
module mbb_decode
  import mbb_pkg::*;
(
  mbb_bank_if.dec            bk,
  input  wire logic [31:0]   addr,
  output logic      [7:0]    hit
);
  // ********************************************************
  // Bound formation and compare
  // ********************************************************
  genvar g;
  generate
    for (g = 0; g < MBB_BANKS; g++) begin : g_bank
      logic [31:0] lo;
      logic [31:0] hi;
      assign lo = {MBB_TOP_ZERO, bk.sext_f[g], bk.start_f[g], MBB_LOW_ZERO};
      assign hi = {MBB_TOP_ZERO, bk.eext_f[g], bk.end_f[g], MBB_LOW_ONES};
      // Disabled bank never hits, even with overlapping bounds
      assign hit[g] = bk.enable[g] && (addr >= lo) && (addr <= hi);
    end
  endgenerate
endmodule
`default_nettype wire

// *** rtl/mbb_regs.sv ***
// Module: APB register bank for memory bank boundaries, enables and memory-go
`timescale 1ns/10ps
`default_nettype none
module mbb_regs
  import mbb_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [31:0]   mem_addr,
  output logic      [7:0]    bank_hit,
  output logic               mem_hit,
  output logic               memory_go_bit
);
  // ********************************************************
  // Register storage
  // ********************************************************
  logic [31:0] start_lo_r;
  logic [31:0] start_hi_r;
  logic [31:0] sext_lo_r;
  logic [31:0] sext_hi_r;
  logic [31:0] end_lo_r;
  logic [31:0] end_hi_r;
  logic [31:0] eext_lo_r;
  logic [31:0] eext_hi_r;
  logic [31:0] bank_en_r;
  logic [31:0] mem_ctrl_r;
  logic [31:0] rdata_nxt;
  logic        known;
  logic        wr_en;
  logic        rd_setup;
  logic [7:0]  hit_w;
  mbb_bank_if  bk ();

  // Byte-lane merge; reserved bits are forced low by the mask
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] st, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  function automatic logic is_off(input logic [31:0] a, input logic [7:0] off);
    return (a[31:8] == 24'h00_0000) && (a[7:0] == off);
  endfunction

  // ********************************************************
  // Bus handshake
  // ********************************************************
  assign wr_en    = psel && penable && pwrite && known;
  assign rd_setup = psel && !penable && !pwrite;
  // Zero-wait slave: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !known;

  // ********************************************************
  // Address decode and read mux
  // ********************************************************
  always_comb begin
    known     = 1'b1;
    rdata_nxt = MBB_RST_WORD;
    if (is_off(paddr, MBB_OFF_START_LO)) begin
      rdata_nxt = start_lo_r;
    end else if (is_off(paddr, MBB_OFF_START_HI)) begin
      rdata_nxt = start_hi_r;
    end else if (is_off(paddr, MBB_OFF_SEXT_LO)) begin
      rdata_nxt = sext_lo_r;
    end else if (is_off(paddr, MBB_OFF_SEXT_HI)) begin
      rdata_nxt = sext_hi_r;
    end else if (is_off(paddr, MBB_OFF_END_LO)) begin
      rdata_nxt = end_lo_r;
    end else if (is_off(paddr, MBB_OFF_END_HI)) begin
      rdata_nxt = end_hi_r;
    end else if (is_off(paddr, MBB_OFF_EEXT_LO)) begin
      rdata_nxt = eext_lo_r;
    end else if (is_off(paddr, MBB_OFF_EEXT_HI)) begin
      rdata_nxt = eext_hi_r;
    end else if (is_off(paddr, MBB_OFF_BANK_EN)) begin
      rdata_nxt = bank_en_r;
    end else if (is_off(paddr, MBB_OFF_MEM_CTRL)) begin
      rdata_nxt = mem_ctrl_r;
    end else if (is_off(paddr, MBB_OFF_HIT_STATUS)) begin
      rdata_nxt = {24'h00_0000, hit_w};
    end else begin
      known = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= MBB_RST_WORD;
    end else if (rd_setup) begin
      prdata <= rdata_nxt;
    end
  end

  // ********************************************************
  // Boundary registers
  // ********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_lo_r <= MBB_RST_WORD;
    end else if (wr_en && is_off(paddr, MBB_OFF_START_LO)) begin
      start_lo_r <= merge(start_lo_r, pwdata, pstrb, ~MBB_RST_WORD);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_hi_r <= MBB_RST_WORD;
    end else if (wr_en && is_off(paddr, MBB_OFF_START_HI)) begin
      start_hi_r <= merge(start_hi_r, pwdata, pstrb, ~MBB_RST_WORD);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sext_lo_r <= MBB_RST_WORD;
    end else if (wr_en && is_off(paddr, MBB_OFF_SEXT_LO)) begin
      sext_lo_r <= merge(sext_lo_r, pwdata, pstrb, MBB_EXT_MASK);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sext_hi_r <= MBB_RST_WORD;
    end else if (wr_en && is_off(paddr, MBB_OFF_SEXT_HI)) begin
      sext_hi_r <= merge(sext_hi_r, pwdata, pstrb, MBB_EXT_MASK);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      end_lo_r <= MBB_RST_WORD;
    end else if (wr_en && is_off(paddr, MBB_OFF_END_LO)) begin
      end_lo_r <= merge(end_lo_r, pwdata, pstrb, ~MBB_RST_WORD);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      end_hi_r <= MBB_RST_WORD;
    end else if (wr_en && is_off(paddr, MBB_OFF_END_HI)) begin
      end_hi_r <= merge(end_hi_r, pwdata, pstrb, ~MBB_RST_WORD);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eext_lo_r <= MBB_RST_WORD;
    end else if (wr_en && is_off(paddr, MBB_OFF_EEXT_LO)) begin
      eext_lo_r <= merge(eext_lo_r, pwdata, pstrb, MBB_EXT_MASK);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eext_hi_r <= MBB_RST_WORD;
    end else if (wr_en && is_off(paddr, MBB_OFF_EEXT_HI)) begin
      eext_hi_r <= merge(eext_hi_r, pwdata, pstrb, MBB_EXT_MASK);
    end
  end

  // ********************************************************
  // Enable and memory-go registers
  // ********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_en_r <= MBB_RST_WORD;
    end else if (wr_en && is_off(paddr, MBB_OFF_BANK_EN)) begin
      bank_en_r <= merge(bank_en_r, pwdata, pstrb, MBB_EN_MASK);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ctrl_r <= MBB_RST_WORD;
    end else if (wr_en && is_off(paddr, MBB_OFF_MEM_CTRL)) begin
      mem_ctrl_r <= merge(mem_ctrl_r, pwdata, pstrb, MBB_GO_MASK);
    end
  end

  // ********************************************************
  // Field unpacking and decode
  // ********************************************************
  genvar g;
  generate
    for (g = 0; g < MBB_HALF; g++) begin : g_unpack
      assign bk.start_f[g]          = start_lo_r[g*MBB_LANE_W +: MBB_LANE_W];
      assign bk.start_f[g+MBB_HALF] = start_hi_r[g*MBB_LANE_W +: MBB_LANE_W];
      assign bk.sext_f[g]           = sext_lo_r[g*MBB_LANE_W +: MBB_EXT_W];
      assign bk.sext_f[g+MBB_HALF]  = sext_hi_r[g*MBB_LANE_W +: MBB_EXT_W];
      assign bk.end_f[g]            = end_lo_r[g*MBB_LANE_W +: MBB_LANE_W];
      assign bk.end_f[g+MBB_HALF]   = end_hi_r[g*MBB_LANE_W +: MBB_LANE_W];
      assign bk.eext_f[g]           = eext_lo_r[g*MBB_LANE_W +: MBB_EXT_W];
      assign bk.eext_f[g+MBB_HALF]  = eext_hi_r[g*MBB_LANE_W +: MBB_EXT_W];
    end
  endgenerate
  assign bk.enable = bank_en_r[7:0];

  mbb_decode u_dec (
    .bk   (bk),
    .addr (mem_addr),
    .hit  (hit_w)
  );

  // bank_hit and mem_hit are gated by memory-go; hit status at 0xA4 reads the ungated decode
  assign memory_go_bit = mem_ctrl_r[MBB_MEMORY_GO_BIT_BIT];
  assign bank_hit      = memory_go_bit ? hit_w : 8'h00;
  assign mem_hit       = |bank_hit;
endmodule
`default_nettype wire

// *** verification/mbb_regs_chk.sv ***
// Checker: port assertions for the boundary register bank
`timescale 1ns/10ps
`default_nettype none
module mbb_regs_chk
  import mbb_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] mem_addr,
  input wire logic [7:0]  bank_hit,
  input wire logic        mem_hit,
  input wire logic        memory_go_bit
);
  // ****
  // Shadow enables, so a disabled bank is judged without the design
  // ****
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] en_q;
  wire acc = psel && penable && pready;
  wire wr = acc && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) en_q <= 8'h00;
    else if (wr && paddr == 32'h0000_00A0 && pstrb[0]) en_q <= pwdata[7:0];
  end
  chk_ready_high: assert property (pready) else $error("pready low");
  chk_go_gates: assert property (!memory_go_bit |-> bank_hit == 8'h00)
    else $error("hit before go");
  chk_hit_or: assert property (mem_hit == (|bank_hit))
    else $error("mem_hit not OR of hits");
  chk_en_gates: assert property ((bank_hit & ~en_q) == 8'h00)
    else $error("disabled bank hit");
  chk_go_write: assert property (wr && paddr == 32'h0000_00F0 && pstrb[2]
    |=> memory_go_bit == $past(pwdata[19])) else $error("go bit not written");
  chk_ext_rsvd: assert property (acc && !pwrite && paddr inside {32'h0000_0088,
    32'h0000_008C, 32'h0000_0098, 32'h0000_009C} |-> (prdata & ~MBB_EXT_MASK) == 32'h0000_0000)
    else $error("reserved ext bits set");
  chk_en_rsvd: assert property (acc && !pwrite && paddr == 32'h0000_00A0
    |-> prdata[31:8] == 24'h00_0000) else $error("reserved enable bits set");
  chk_unmapped_err: assert property (psel && penable && paddr[31:8] != 24'h00_0000 |-> pslverr)
    else $error("no error on unmapped");
  chk_hit_steady: assert property (!$past(wr) && $stable(mem_addr) |-> $stable(bank_hit))
    else $error("hit moved without cause");
  cov_go: cover property ($rose(memory_go_bit));
  cov_hit: cover property (mem_hit);
  cov_err: cover property (pslverr && acc);
endmodule
bind mbb_regs mbb_regs_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .prdata, .pready, .pslverr, .mem_addr, .bank_hit, .mem_hit, .memory_go_bit);
`default_nettype wire

// *** verification/test_memory_bank_boundary_regs.sv ***
// Testbench: directed APB and decode scenarios for the boundary register bank
`timescale 1ns/10ps
`default_nettype none
module test_memory_bank_boundary_regs
  import mbb_pkg::*;
;
  // ****
  // Stimulus and checking
  // ****
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_hit, memory_go_bit, err;
  logic [31:0] paddr, pwdata, prdata, mem_addr, rd;
  logic [3:0] pstrb;
  logic [7:0] bank_hit;
  int mismatches, samples_checked;
  mbb_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .mem_addr, .bank_hit, .mem_hit, .memory_go_bit);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmp32(input logic [31:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask
  // Holds the request until pready is seen high; a stuck bus ends the run
  task automatic apb(input logic w, input logic [31:0] a, d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: no pready", $time);
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic probe(input logic [31:0] a, input logic [7:0] exp);
    @(posedge pclk);
    mem_addr <= a;
    @(posedge pclk);
    #1;
    cmp32({24'h0, bank_hit}, {24'h0, exp}, "bank_hit");
    cmp32({31'h0, mem_hit}, {31'h0, |exp}, "mem_hit");
  endtask
  function automatic logic [7:0] sf(int n);
    return 8'(n * 32);
  endfunction
  function automatic logic [31:0] lo(int n);
    return {2'h0, 2'(n), sf(n), 20'h0_0000};
  endfunction
  function automatic logic [31:0] hi(int n);
    return {2'h0, 2'(n), sf(n) + 8'h1F, 20'hF_FFFF};
  endfunction
  // Word for register 0x80+4r; ext bytes carry ones in reserved bits
  function automatic logic [31:0] word(int r);
    logic [31:0] v;
    int n;
    for (int i = 0; i < 4; i++) begin
      n = (r % 2) * 4 + i;
      v[8*i +: 8] = (r / 2) % 2 ? {6'h3F, 2'(n)} : sf(n) + ((r / 2) == 2 ? 8'h1F : 8'h00);
    end
    return v;
  endfunction
  task automatic t_reset;
    for (int r = 0; r < 9; r++) begin
      apb(1'b0, 32'h0000_0080 + 32'(4 * r), 32'h0000_0000);
      cmp32(rd, 32'h0000_0000, "reset value");
    end
    cmp32({31'h0, memory_go_bit}, 32'h0000_0000, "go at reset");
    $display("test reset done");
  endtask
  task automatic t_layout;
    for (int r = 0; r < 8; r++) apb(1'b1, 32'h0000_0080 + 32'(4 * r), word(r));
    for (int r = 0; r < 8; r++) begin
      apb(1'b0, 32'h0000_0080 + 32'(4 * r), 32'h0000_0000);
      cmp32(rd, (r / 2) % 2 ? word(r) & MBB_EXT_MASK : word(r), "readback");
    end
    $display("test layout done");
  endtask
  task automatic t_decode;
    apb(1'b1, 32'h0000_00A0, 32'hFFFF_FFFF);
    apb(1'b0, 32'h0000_00A0, 32'h0000_0000);
    cmp32(rd, 32'h0000_00FF, "enable");
    probe(lo(3), 8'h00);
    apb(1'b1, 32'h0000_00F0, 32'hFFFF_FFFF);
    apb(1'b0, 32'h0000_00F0, 32'h0000_0000);
    cmp32(rd, MBB_GO_MASK, "control readback");
    cmp32({31'h0, memory_go_bit}, 32'h0000_0001, "go set");
    for (int n = 0; n < 8; n++) begin
      probe(lo(n), 8'(1 << n));
      probe(hi(n), 8'(1 << n));
      probe(lo(n) - 32'h1, 8'h00);
      probe(hi(n) + 32'h1, 8'h00);
    end
    apb(1'b1, 32'h0000_00A0, 32'h0000_00FB);
    probe(lo(2), 8'h00);
    probe(hi(5), 8'h20);
    apb(1'b0, 32'h0000_00A4, 32'h0000_0000);
    cmp32(rd, 32'h0000_0020, "raw hit status");
    $display("test decode done");
  endtask
  task automatic t_unmapped;
    apb(1'b1, 32'h0000_0040, 32'hFFFF_FFFF);
    cmp32({31'h0, err}, 32'h0000_0001, "write err");
    apb(1'b0, 32'h0000_0040, 32'h0000_0000);
    cmp32(rd, 32'h0000_0000, "unmapped data");
    cmp32({31'h0, err}, 32'h0000_0001, "read err");
    apb(1'b0, 32'h0000_0080, 32'h0000_0000);
    cmp32(rd, word(0), "start after error");
    pstrb <= 4'h2;
    apb(1'b1, 32'h0000_0080, 32'hFFFF_FFFF);
    pstrb <= 4'hF;
    apb(1'b0, 32'h0000_0080, 32'h0000_0000);
    cmp32(rd, word(0) | 32'h0000_FF00, "lane write");
    $display("test unmapped done");
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, mem_addr} = '0;
    pstrb = 4'hF;
    mismatches = 0;
    samples_checked = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_layout();
    t_decode();
    t_unmapped();
    finish_test();
  end
endmodule
`default_nettype wire
